// ==== src/multifunction_terminal_router.sv ====
// multifunction terminal router: pin functions, speaker, ring output, suspend guard
`timescale 1ns/1ns
`default_nettype none
module multifunction_terminal_router import mft_pkg::*; (
	input wire logic mclk, // system clock
	input wire logic sys_rst, // async reset
	input wire logic global_reset, // global reset level
	input wire logic pci_reset_in, // pci reset level
	input wire logic suspend, // suspend input
	input wire logic serial_strap, // strap, low enables two-wire bus
	input wire logic micro_clock_in, // microcontroller clock, passed on only
	output logic micro_clock_out, // clock to the microcontroller
	input wire logic [SEL_W*NUM_TERMS-1:0] term_sel, // function code per terminal
	input wire fn_src_s fn_src, // internal function sources
	input wire logic [1:0] card_speaker_in, // card speaker per socket
	input wire logic [1:0] card_audio_in, // card audio per socket
	input wire logic ring_indicate, // ring indicate source
	input wire logic power_event, // power event source
	input wire logic ring_sel_pme, // 1 selects power event on ring pin
	input wire logic [15:0] prot_wdata, // protected register write data
	input wire logic prot_we, // protected register write
	output logic [15:0] prot_value, // protected register contents
	input wire logic [NUM_TERMS-1:0] term_in, // pin levels
	output logic [NUM_TERMS-1:0] term_out, // pin drive values
	output logic [NUM_TERMS-1:0] term_oe, // pin drive enables
	output logic [NUM_GP-1:0] general_input, // gp inputs seen on pins
	output logic general_event, // event input seen on a pin
	output logic pci_lock_in, // lock level from terminal 4
	output logic serialized_interrupt_in, // serialized irq level
	output logic clkrun_in, // clkrun level from terminal 6
	output logic serial_en, // two-wire bus active
	output logic [8*EEPROM_BYTES-1:0] eeprom_defaults, // loaded defaults
	output logic eeprom_busy, // load in progress
	output logic speaker_out, // speaker to host
	output logic ring_indicate_out // ring or power event pin
);
	// allowed codes per terminal, bit n = function code n
	localparam logic [15:0] ALLOW0 = 16'h02FE;
	localparam logic [15:0] ALLOW1 = 16'h02FE;
	localparam logic [15:0] ALLOW2 = 16'h03FC;
	localparam logic [15:0] ALLOW3 = 16'h0600;
	localparam logic [15:0] ALLOW4 = 16'h0BFC;
	localparam logic [15:0] ALLOW5 = 16'h02FC;
	localparam logic [15:0] ALLOW6 = 16'h1200;
	localparam logic [16*NUM_TERMS-1:0] ALLOW_ALL =
		{ALLOW6, ALLOW5, ALLOW4, ALLOW3, ALLOW2, ALLOW1, ALLOW0};
	// gp index per terminal; terminals 3 and 6 have none
	localparam logic [3*NUM_TERMS-1:0] GP_IDX =
		{3'h0, 3'h4, 3'h3, 3'h0, 3'h2, 3'h1, 3'h0};

	logic serial_en_n, next_serial_en;
	logic [15:0] next_prot;
	logic pci_rst_d, next_pci_rst_d;
	logic load_start;
	logic sda_oe, scl_oe;
	pin_drive_s [NUM_TERMS-1:0] drv;

	assign micro_clock_out = micro_clock_in;

	// strap caught while global reset is held; the clock keeps running then
	always_comb begin
		next_serial_en = serial_en;
		if (global_reset) begin
			next_serial_en = ~serial_strap;
		end
	end
	assign serial_en_n = ~serial_en;

	// protected register: global and pci resets clear it only without suspend; sys_rst clears it always
	always_comb begin
		next_prot = prot_value;
		if ((global_reset || pci_reset_in) && !suspend) begin
			next_prot = 16'h0000;
		end else if (prot_we) begin
			next_prot = prot_wdata;
		end
	end

	// pci reset release edge starts the eeprom load
	assign next_pci_rst_d = pci_reset_in;
	assign load_start = pci_rst_d && !pci_reset_in && serial_en;

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			serial_en <= SERIAL_EN_RST;
			prot_value <= 16'h0000;
			pci_rst_d <= 1'b0;
		end else begin
			serial_en <= next_serial_en;
			prot_value <= next_prot;
			pci_rst_d <= next_pci_rst_d;
		end
	end

	eeprom_loader u_loader (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.start(load_start),
		.sda_in(term_in[1]),
		.sda_oe(sda_oe),
		.scl_oe(scl_oe),
		.data(eeprom_defaults),
		.busy(eeprom_busy)
	);

	// per-terminal function selection
	genvar t;
	generate
		for (t = 0; t < NUM_TERMS; t++) begin : g_term
			logic [15:0] val;
			logic [15:0] den;
			pin_drive_s d;
			always_comb begin
				val = 16'h0000;
				den = 16'h0000;
				val[FN_PCI_INT] = 1'b0; // interrupts pull low, open drain
				den[FN_PCI_INT] = (t == 0) ? fn_src.inta : fn_src.intb;
				val[FN_GP_OUT] = fn_src.gp_out[GP_IDX[3*t +: 3]];
				den[FN_GP_OUT] = 1'b1;
				val[FN_ACTIVITY] = fn_src.activity;
				den[FN_ACTIVITY] = 1'b1;
				val[FN_VIDEO] = fn_src.video;
				den[FN_VIDEO] = 1'b1;
				val[FN_AUDIO_PWM] = fn_src.audio_pwm;
				den[FN_AUDIO_PWM] = 1'b1;
				val[FN_RING_OUT] = ring_indicate;
				den[FN_RING_OUT] = 1'b1;
				val[FN_IRQ] = fn_src.irq[t];
				den[FN_IRQ] = 1'b1;
				val[FN_SER_IRQ] = fn_src.irq_ser_out;
				den[FN_SER_IRQ] = fn_src.irq_ser_oe;
				val[FN_CLKRUN] = fn_src.clkrun_out;
				den[FN_CLKRUN] = fn_src.clkrun_oe;
			end
			term_mux #(.ALLOWED(ALLOW_ALL[16*t +: 16])) u_mux (
				.sel(term_fn_e'(term_sel[SEL_W*t +: SEL_W])),
				.fn_val(val),
				.fn_drv(den),
				.drv(d)
			);
			assign drv[t] = d;
		end
	endgenerate

	// two-wire bus overrides terminals 1 and 4; both are open drain
	always_comb begin
		for (int i = 0; i < NUM_TERMS; i++) begin
			term_out[i] = drv[i].out;
			term_oe[i] = drv[i].oe;
		end
		if (serial_en) begin
			term_out[1] = 1'b0;
			term_oe[1] = sda_oe;
			term_out[4] = 1'b0;
			term_oe[4] = scl_oe;
		end
	end

	// inputs seen through their selected terminals
	always_comb begin
		general_input = '0;
		general_event = 1'b0;
		for (int i = 0; i < NUM_TERMS; i++) begin
			if (ALLOW_ALL[16*i + FN_GP_IN] && term_sel[SEL_W*i +: SEL_W] == FN_GP_IN &&
				!(serial_en && (i == 1 || i == 4))) begin
				general_input[GP_IDX[3*i +: 3]] = term_in[i];
			end
			if (ALLOW_ALL[16*i + FN_GEN_EVENT] && term_sel[SEL_W*i +: SEL_W] == FN_GEN_EVENT
				&& !(serial_en && (i == 1 || i == 4))) begin
				general_event = general_event | term_in[i];
			end
		end
	end

	assign pci_lock_in = serial_en_n && term_sel[SEL_W*4 +: SEL_W] == FN_PCI_LOCK && term_in[4];
	assign serialized_interrupt_in = term_sel[SEL_W*3 +: SEL_W] == FN_SER_IRQ && term_in[3];
	assign clkrun_in = term_sel[SEL_W*6 +: SEL_W] == FN_CLKRUN && term_in[6];

	// speaker is a pure xor of both sockets' sources
	assign speaker_out = ^{card_speaker_in, card_audio_in};

	// dedicated ring pin carries one of two sources
	assign ring_indicate_out = ring_sel_pme ? power_event : ring_indicate;

endmodule : multifunction_terminal_router
`default_nettype wire

// ==== src/mft_pkg.sv ====
// shared types and constants for the multifunction terminal router
package mft_pkg;

	localparam int NUM_TERMS = 7;
	localparam int NUM_GP = 5;
	localparam int SEL_W = 4;

	// function codes per terminal; codes a terminal does not offer read as none
	typedef enum logic [3:0] {
		FN_NONE = 4'h0,
		FN_PCI_INT = 4'h1,
		FN_GP_IN = 4'h2,
		FN_GP_OUT = 4'h3,
		FN_ACTIVITY = 4'h4,
		FN_VIDEO = 4'h5,
		FN_AUDIO_PWM = 4'h6,
		FN_GEN_EVENT = 4'h7,
		FN_RING_OUT = 4'h8,
		FN_IRQ = 4'h9,
		FN_SER_IRQ = 4'hA,
		FN_PCI_LOCK = 4'hB,
		FN_CLKRUN = 4'hC
	} term_fn_e;

	// drive of one pin: value and enable
	typedef struct packed {
		logic out;
		logic oe;
	} pin_drive_s;

	// internal function sources, one bit per source
	typedef struct packed {
		logic inta;
		logic intb;
		logic [NUM_GP-1:0] gp_out;
		logic activity;
		logic video;
		logic audio_pwm;
		logic irq_ser_out;
		logic irq_ser_oe;
		logic clkrun_out;
		logic clkrun_oe;
		logic [NUM_TERMS-1:0] irq;
	} fn_src_s;

	// reset value of the two-wire enable latch: disabled
	localparam logic SERIAL_EN_RST = 1'b0;
	// eeprom loader timing: scl half period in mclk cycles
	localparam int SCL_HALF_CYC = 5;
	localparam logic [6:0] EEPROM_DEV_ADDR = 7'h50;
	localparam int EEPROM_BYTES = 4;

	typedef enum logic [2:0] {
		LD_IDLE = 3'b000,
		LD_START = 3'b001,
		LD_SHIFT = 3'b011,
		LD_ACK = 3'b010,
		LD_STOP = 3'b110,
		LD_DONE = 3'b111
	} loader_e;

endpackage : mft_pkg

// ==== src/term_mux.sv ====
// one multifunction terminal: selects the driven function per code
`timescale 1ns/1ns
`default_nettype none
module term_mux import mft_pkg::*; #(
	parameter logic [15:0] ALLOWED = 16'h0000
) (
	input wire term_fn_e sel, // selected function
	input wire logic [15:0] fn_val, // value per function code
	input wire logic [15:0] fn_drv, // output enable per function code
	output var pin_drive_s drv // resulting pin drive
);
	// unsupported or input codes leave the driver off
	always_comb begin
		drv.out = 1'b0;
		drv.oe = 1'b0;
		if (ALLOWED[sel] && fn_drv[sel]) begin
			drv.out = fn_val[sel];
			drv.oe = 1'b1;
		end
	end
endmodule : term_mux
`default_nettype wire

// ==== src/eeprom_loader.sv ====
// minimal two-wire reader that fetches register defaults after pci reset
`timescale 1ns/1ns
`default_nettype none
module eeprom_loader import mft_pkg::*; (
	input wire logic mclk, // system clock
	input wire logic sys_rst, // async reset
	input wire logic start, // pulse: begin load
	input wire logic sda_in, // data line level
	output logic sda_oe, // pull data low
	output logic scl_oe, // pull clock low
	output logic [8*EEPROM_BYTES-1:0] data, // loaded defaults
	output logic busy // load in progress
);
	loader_e state, next_state;
	logic [7:0] div, next_div;
	logic phase, next_phase;
	logic [3:0] bitn, next_bitn;
	logic [7:0] sh, next_sh;
	logic [2:0] byten, next_byten;
	logic [8*EEPROM_BYTES-1:0] next_data;
	logic sda_o, next_sda_o;
	logic scl_o, next_scl_o;

	assign sda_oe = ~sda_o;
	assign scl_oe = ~scl_o;
	assign busy = (state != LD_IDLE) && (state != LD_DONE);

	// simple read: address byte then bytes clocked in, no random addressing
	always_comb begin
		next_state = state;
		next_div = div;
		next_phase = phase;
		next_bitn = bitn;
		next_sh = sh;
		next_byten = byten;
		next_data = data;
		next_sda_o = sda_o;
		next_scl_o = scl_o;
		if (start) begin
			next_state = LD_START;
			next_div = 8'h00;
			next_byten = 3'h0;
		end else if (busy) begin
			if (div == 8'(SCL_HALF_CYC - 1)) begin
				next_div = 8'h00;
				next_phase = ~phase;
				case (state)
					LD_START: begin
						next_sda_o = 1'b0;
						next_sh = {EEPROM_DEV_ADDR, 1'b1};
						next_bitn = 4'h0;
						next_phase = 1'b0;
						next_state = LD_SHIFT;
					end
					LD_SHIFT: begin
						if (!phase) begin
							next_scl_o = 1'b0;
						end else begin
							next_scl_o = 1'b1;
						end
						if (!phase) begin
							next_sda_o = (byten == 3'h0) ? sh[7] : 1'b1;
						end else begin
							next_sh = {sh[6:0], sda_in};
							next_bitn = bitn + 4'h1;
							if (bitn == 4'h7) begin
								next_state = LD_ACK;
							end
						end
					end
					LD_ACK: begin
						next_scl_o = phase;
						if (!phase) begin
							next_sda_o = (byten == 3'(EEPROM_BYTES)) ? 1'b1 :
								(byten == 3'h0) ? 1'b1 : 1'b0;
						end else begin
							if (byten != 3'h0) begin
								next_data = {data[8*EEPROM_BYTES-9:0], sh};
							end
							next_byten = byten + 3'h1;
							next_bitn = 4'h0;
							next_state = (byten == 3'(EEPROM_BYTES)) ? LD_STOP : LD_SHIFT;
						end
					end
					LD_STOP: begin
						next_scl_o = 1'b1;
						next_sda_o = phase;
						if (phase) begin
							next_state = LD_DONE;
						end
					end
					default: next_state = LD_IDLE;
				endcase
			end else begin
				next_div = div + 8'h01;
			end
		end
	end

	// registers only
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= LD_IDLE;
			div <= 8'h00;
			phase <= 1'b0;
			bitn <= 4'h0;
			sh <= 8'h00;
			byten <= 3'h0;
			data <= '0;
			sda_o <= 1'b1;
			scl_o <= 1'b1;
		end else begin
			state <= next_state;
			div <= next_div;
			phase <= next_phase;
			bitn <= next_bitn;
			sh <= next_sh;
			byten <= next_byten;
			data <= next_data;
			sda_o <= next_sda_o;
			scl_o <= next_scl_o;
		end
	end
endmodule : eeprom_loader
`default_nettype wire

// ==== tb/router_assertions.sv ====
// port-level checks for the multifunction terminal router
`timescale 1ns/1ns
`default_nettype none
module router_checker import mft_pkg::*; (
	input wire logic mclk, // clock
	input wire logic sys_rst, // reset
	input wire logic global_reset, // global reset
	input wire logic pci_reset_in, // pci reset
	input wire logic suspend, // guard
	input wire logic serial_strap, // strap
	input wire logic [SEL_W*NUM_TERMS-1:0] term_sel, // codes
	input wire fn_src_s fn_src, // sources
	input wire logic [1:0] card_speaker_in, // speaker
	input wire logic [1:0] card_audio_in, // audio
	input wire logic ring_indicate, // ring
	input wire logic power_event, // event
	input wire logic ring_sel_pme, // select
	input wire logic [15:0] prot_wdata, // data
	input wire logic prot_we, // write
	input wire logic [15:0] prot_value, // register
	input wire logic [NUM_TERMS-1:0] term_out, // values
	input wire logic [NUM_TERMS-1:0] term_oe, // enables
	input wire logic serial_en, // two-wire on
	input wire logic eeprom_busy, // loading
	input wire logic speaker_out, // speaker
	input wire logic ring_indicate_out // ring pin
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	logic [NUM_TERMS-1:0] quiet;
	logic clr;
	// pins that must stay undriven; sda and scl belong to the loader when enabled
	always_comb begin
		for (int t = 0; t < NUM_TERMS; t++) begin
			quiet[t] = (term_sel[4*t+:4] inside {FN_NONE, FN_GP_IN, FN_GEN_EVENT, FN_PCI_LOCK})
				&& !(serial_en && (t == 1 || t == 4));
		end
	end
	assign clr = (global_reset || pci_reset_in) && !suspend;
	a_speaker_xor: assert property (speaker_out == ^{card_speaker_in, card_audio_in})
		else $error("speaker output is not the xor");
	a_ring_select: assert property (ring_indicate_out == (ring_sel_pme ? power_event : ring_indicate))
		else $error("ring pin shows the wrong source");
	a_idle_quiet: assert property ((term_oe & quiet) == 7'h00)
		else $error("input terminal is driven");
	a_gp_drive: assert property (term_sel[3:0] == FN_GP_OUT |-> term_oe[0] && term_out[0] == fn_src.gp_out[0])
		else $error("general output 0 not on terminal 0");
	a_strap_latch: assert property (global_reset |=> serial_en == !$past(serial_strap))
		else $error("strap not latched");
	a_strap_hold: assert property (!global_reset |=> $stable(serial_en))
		else $error("two-wire enable moved outside global reset");
	a_prot_write: assert property (prot_we && !clr |=> prot_value == $past(prot_wdata))
		else $error("protected write lost");
	a_prot_clear: assert property (clr |=> prot_value == 16'h0000)
		else $error("unsuspended reset did not clear");
	a_prot_keep: assert property (suspend && !prot_we |=> $stable(prot_value))
		else $error("suspended register changed");
	a_load_start: assert property (serial_en && $fell(pci_reset_in) |-> ##[1:2] eeprom_busy)
		else $error("eeprom load did not start");
endmodule : router_checker
`default_nettype wire

// ==== tb/host_side_model.sv ====
// host side: pull-ups, external pin drivers and the microcontroller clock
`timescale 1ns/1ns
`default_nettype none
module host_side_model import mft_pkg::*; (
	input wire logic [NUM_TERMS-1:0] term_out, // device values
	input wire logic [NUM_TERMS-1:0] term_oe, // device enables
	input wire logic [NUM_TERMS-1:0] ext_val, // host values
	input wire logic [NUM_TERMS-1:0] ext_oe, // host enables
	output logic [NUM_TERMS-1:0] term_in, // pin levels
	output logic micro_clock // about 48 MHz
);
	// the system supplies the microcontroller clock; 21 ns is the nearest whole step
	initial begin
		micro_clock = 1'b0;
		forever begin
			#10 micro_clock = 1'b1;
			#11 micro_clock = 1'b0;
		end
	end
	// device drive wins; a pin nobody drives floats to its pull-up
	always_comb begin
		for (int t = 0; t < NUM_TERMS; t++) begin
			term_in[t] = term_oe[t] ? term_out[t] : (ext_oe[t] ? ext_val[t] : 1'b1);
		end
	end
endmodule : host_side_model
`default_nettype wire

// ==== tb/multifunction_terminal_router_tb_top.sv ====
// self-checking bench for the multifunction terminal router
`timescale 1ns/1ns
`default_nettype none
module multifunction_terminal_router_tb_top import mft_pkg::*; ();
	localparam logic [15:0] ALLOW [NUM_TERMS] = '{16'h02FE, 16'h02FE, 16'h03FC, 16'h0600,
		16'h0BFC, 16'h02FC, 16'h1200};
	localparam logic [15:0] OUTM = 16'h0378; // push-pull output codes, parallel irq included
	localparam logic [15:0] INM = 16'h0884; // pure input codes
	logic mclk = 1'b0, sys_rst = 1'b1, global_reset = 1'b0, pci_reset_in = 1'b0;
	logic suspend = 1'b0, serial_strap = 1'b1, ring_indicate = 1'b0, power_event = 1'b0;
	logic ring_sel_pme = 1'b0, prot_we = 1'b0, micro_clock_in, micro_clock_out, ok, prev;
	logic [SEL_W*NUM_TERMS-1:0] term_sel = 28'h0000000;
	fn_src_s fn_src = '0;
	logic [1:0] card_speaker_in = 2'h0, card_audio_in = 2'h0;
	logic [15:0] prot_wdata = 16'h0000, prot_value;
	logic [NUM_TERMS-1:0] term_in, term_out, term_oe, ext_val = 7'h00, ext_oe = 7'h7F;
	logic [NUM_GP-1:0] general_input;
	logic general_event, pci_lock_in, serialized_interrupt_in, clkrun_in, serial_en;
	logic eeprom_busy, speaker_out, ring_indicate_out;
	logic [8*EEPROM_BYTES-1:0] eeprom_defaults;
	int mismatches = 0, n_tests = 0, n, tog;
	multifunction_terminal_router i_dut (.mclk, .sys_rst, .global_reset, .pci_reset_in,
		.suspend, .serial_strap, .micro_clock_in, .micro_clock_out, .term_sel, .fn_src,
		.card_speaker_in, .card_audio_in, .ring_indicate, .power_event, .ring_sel_pme,
		.prot_wdata, .prot_we, .prot_value, .term_in, .term_out, .term_oe, .general_input,
		.general_event, .pci_lock_in, .serialized_interrupt_in, .clkrun_in, .serial_en,
		.eeprom_defaults, .eeprom_busy, .speaker_out, .ring_indicate_out);
	host_side_model i_host (.term_out, .term_oe, .ext_val, .ext_oe, .term_in,
		.micro_clock(micro_clock_in));
	// 10 MHz system clock
	initial begin
		forever #50 mclk = ~mclk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic cyc(input int k);
		repeat (k) @(posedge mclk);
	endtask : cyc
	task automatic tally_and_finish;
		if (mismatches == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : tally_and_finish
	// a wait that overruns its bound counts as a failure and ends the run
	task automatic guard(input int cnt, input int lim);
		if (cnt > lim) begin
			mismatches++;
			tally_and_finish();
		end
	endtask : guard
	initial begin
		cyc(5);
		sys_rst <= 1'b0;
		// every code on every terminal, with sources and pins low then high
		for (int t = 0; t < NUM_TERMS; t++) begin
			for (int c = 0; c < 16; c++) begin
				for (int v = 0; v < 2; v++) begin
					cyc(1);
					term_sel <= {24'h000000, 4'(c)} << (4 * t);
					fn_src <= {$bits(fn_src_s){v[0]}};
					ring_indicate <= v[0];
					ext_val <= {NUM_TERMS{v[0]}};
					#10;
					ok = ALLOW[t][c];
					if (ok && OUTM[c]) begin
						chk(term_oe[t], 1'b1);
						chk(term_out[t], v[0]);
					end else if (!ok || INM[c]) begin
						chk(term_oe[t], 1'b0);
					end else if (c == 1) begin
						// pci interrupt is open drain: pulls low only while asserted
						chk(term_oe[t], v[0]);
						chk(term_out[t], 1'b0);
					end else if (c == 10 || c == 12) begin
						// serialized irq and clkrun drive only when their source enables
						chk(term_oe[t], v[0]);
						chk(term_out[t], v[0]);
					end
					if (ok) begin
						case (c)
							2: chk(general_input[t < 3 ? t : t - 1], v[0]);
							7: chk(general_event, v[0]);
							10: chk(serialized_interrupt_in, v[0]);
							11: chk(pci_lock_in, v[0]);
							12: chk(clkrun_in, v[0]);
							default: ;
						endcase
					end
				end
			end
		end
		// speaker xor and ring pin source over all input combinations
		for (int i = 0; i < 16; i++) begin
			cyc(1);
			{card_speaker_in, card_audio_in} <= 4'(i);
			{ring_indicate, power_event, ring_sel_pme} <= 3'(i);
			#10;
			chk(speaker_out, ^4'(i));
			chk(ring_indicate_out, i[0] ? i[1] : i[2]);
		end
		@(micro_clock_in);
		#1;
		chk(micro_clock_out, micro_clock_in);
		// suspended global and pci resets keep the protected value, an unsuspended pci reset clears it
		cyc(1);
		prot_wdata <= 16'hA5C3;
		prot_we <= 1'b1;
		cyc(1);
		prot_we <= 1'b0;
		#10;
		chk(prot_value, 16'hA5C3);
		cyc(1);
		suspend <= 1'b1;
		global_reset <= 1'b1;
		cyc(2);
		global_reset <= 1'b0;
		pci_reset_in <= 1'b1;
		cyc(2);
		#10;
		chk(prot_value, 16'hA5C3);
		cyc(1);
		suspend <= 1'b0;
		cyc(2);
		#10;
		chk(prot_value, 16'h0000);
		// strap low under global reset hands terminals 1 and 4 to the two-wire bus
		cyc(1);
		pci_reset_in <= 1'b0;
		serial_strap <= 1'b0;
		global_reset <= 1'b1;
		term_sel <= 28'h0000020;
		ext_val <= 7'h7F;
		cyc(2);
		global_reset <= 1'b0;
		serial_strap <= 1'b1;
		cyc(2);
		#10;
		chk(serial_en, 1'b1);
		chk(general_input[1], 1'b0);
		chk(eeprom_busy, 1'b0);
		cyc(1);
		pci_reset_in <= 1'b1;
		cyc(2);
		pci_reset_in <= 1'b0;
		n = 0;
		while (eeprom_busy !== 1'b1) begin
			@(posedge mclk) #1;
			n++;
			guard(n, 5);
		end
		n = 0;
		tog = 0;
		prev = term_oe[4];
		while (eeprom_busy === 1'b1) begin
			@(posedge mclk) #1;
			if (term_oe[4] !== prev) tog++;
			prev = term_oe[4];
			n++;
			guard(n, 5000);
		end
		chk(tog > 0, 1'b1);
		// host holds the data line high, so every loaded byte reads as all ones
		chk(eeprom_defaults, 32'hFFFFFFFF);
		cyc(1);
		global_reset <= 1'b1;
		cyc(2);
		global_reset <= 1'b0;
		cyc(1);
		#10;
		chk(serial_en, 1'b0);
		tally_and_finish();
	end
endmodule : multifunction_terminal_router_tb_top
bind multifunction_terminal_router router_checker i_chk (.mclk, .sys_rst, .global_reset,
	.pci_reset_in, .suspend, .serial_strap, .term_sel, .fn_src, .card_speaker_in,
	.card_audio_in, .ring_indicate, .power_event, .ring_sel_pme, .prot_wdata, .prot_we,
	.prot_value, .term_out, .term_oe, .serial_en, .eeprom_busy, .speaker_out,
	.ring_indicate_out);
`default_nettype wire
